// ==== design/serial_eeprom_bus_slave.sv ====
// What this block does
// - byte-wide array, 64K or 32K locations
// - start, select byte with read/write, ack
// - device acks only the first data byte of a write, ninth clock
// - fixed four-bit type must match select
// - slave only, timed by serial clock
// - select bits 3..1 compared with chip pins
// - write protect: no data ack, no write
// - stop after write starts programming cycle
module serial_eeprom_bus_slave #(
    parameter int ADDR_W = eeprom_slave_pkg::ADDR_W_LARGE,
    parameter logic [3:0] DEV_TYPE = eeprom_slave_pkg::DEV_TYPE_DEFAULT,
    parameter int PROG_CYCLES = eeprom_slave_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // two-wire link
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // strap pins
    input wire logic chip_select_pin_0,
    input wire logic chip_select_pin_1,
    input wire logic chip_select_pin_2,
    input wire logic write_protect_input,
    // status
    output logic prog_busy
);
    localparam int DEPTH = 1 << ADDR_W;
    localparam int PCW = $clog2(PROG_CYCLES + 1);

    eeprom_slave_pkg::link_ev_s ev;
    eeprom_slave_pkg::phase_e phase_r, phase_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic [15:0] addr_r, addr_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic sda_oe_r, sda_oe_nxt;
    logic ack_phase_r, ack_phase_nxt;
    logic busy_r, busy_nxt;
    logic rd_nack_r, rd_nack_nxt;
    logic wr_pend_r, wr_pend_nxt;
    logic [7:0] wbuf_r, wbuf_nxt;
    logic [15:0] waddr_r, waddr_nxt;
    logic [PCW-1:0] pcnt_r, pcnt_nxt;
    logic [2:0] cs_s1_r, cs_s2_r;
    logic wp_s1_r, wp_s2_r;
    logic [7:0] mem_r [DEPTH];
    logic mem_we;
    logic [7:0] byte_in;

    // edge and condition detection with synchronisers
    link_sampler u_link (
        .clk(clk),
        .reset_n(reset_n),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ev(ev)
    );

    // strap synchronisers; open pins read low by pull-down outside
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cs_s1_r <= 3'h0;
            cs_s2_r <= 3'h0;
            wp_s1_r <= 1'b0;
            wp_s2_r <= 1'b0;
        end else begin
            cs_s1_r <= {chip_select_pin_2, chip_select_pin_1,
                        chip_select_pin_0};
            cs_s2_r <= cs_s1_r;
            wp_s1_r <= write_protect_input;
            wp_s2_r <= wp_s1_r;
        end
    end

    // select byte decode
    function automatic logic sel_match(input logic [7:0] b,
                                       input logic [2:0] cs);
        sel_match = (b[eeprom_slave_pkg::SEL_TYPE_HI:
                       eeprom_slave_pkg::SEL_TYPE_LO] == DEV_TYPE)
            && (b[eeprom_slave_pkg::SEL_CS_HI:
                  eeprom_slave_pkg::SEL_CS_LO] == cs);
    endfunction

    assign byte_in = {shift_r[6:0], ev.sda};

    // protocol state machine, sequenced by serial clock edges
    always_comb begin
        phase_nxt = phase_r;
        bit_nxt = bit_r;
        shift_nxt = shift_r;
        addr_nxt = addr_r;
        tx_nxt = tx_r;
        sda_oe_nxt = sda_oe_r;
        ack_phase_nxt = ack_phase_r;
        rd_nack_nxt = rd_nack_r;
        wr_pend_nxt = wr_pend_r;
        wbuf_nxt = wbuf_r;
        waddr_nxt = waddr_r;
        pcnt_nxt = pcnt_r;
        mem_we = 1'b0;
        // programming countdown
        if (pcnt_r != '0) begin
            pcnt_nxt = pcnt_r - 1'b1;
            if (pcnt_r == PCW'(1)) begin
                mem_we = 1'b1;
            end
        end
        if (ev.stop) begin
            // stop after a written byte launches programming
            if (wr_pend_r && pcnt_r == '0) begin
                pcnt_nxt = PCW'(PROG_CYCLES);
            end
            wr_pend_nxt = 1'b0;
            phase_nxt = eeprom_slave_pkg::ST_IDLE;
            sda_oe_nxt = 1'b0;
        end else if (ev.start && pcnt_r == '0) begin
            // every access opens with start and select byte
            phase_nxt = eeprom_slave_pkg::ST_SEL;
            // the clock fall that closes the start is not a data bit
            bit_nxt = eeprom_slave_pkg::BIT_ACK;
            ack_phase_nxt = 1'b1;
            sda_oe_nxt = 1'b0;
            wr_pend_nxt = 1'b0;
        end else if (ev.scl_rise && !ack_phase_r) begin
            if (phase_r != eeprom_slave_pkg::ST_IDLE &&
                phase_r != eeprom_slave_pkg::ST_IGNORE) begin
                shift_nxt = byte_in;
            end
        end else if (ev.scl_rise && ack_phase_r) begin
            // sample master ack on read bytes
            rd_nack_nxt = ev.sda;
        end else if (ev.scl_fall) begin
            case (phase_r)
                eeprom_slave_pkg::ST_IDLE,
                eeprom_slave_pkg::ST_IGNORE: begin
                    sda_oe_nxt = 1'b0;
                end
                default: begin
                    if (ack_phase_r) begin
                        // ninth clock finished
                        ack_phase_nxt = 1'b0;
                        bit_nxt = '0;
                        if (phase_r == eeprom_slave_pkg::ST_RDATA) begin
                            if (rd_nack_r) begin
                                // noack ends the read
                                phase_nxt = eeprom_slave_pkg::ST_IGNORE;
                                sda_oe_nxt = 1'b0;
                            end else begin
                                tx_nxt = mem_r[addr_r[ADDR_W-1:0]];
                                addr_nxt = addr_r + 16'h0001;
                                sda_oe_nxt = !mem_r[addr_r[ADDR_W-1:0]][7];
                            end
                        end else begin
                            sda_oe_nxt = 1'b0;
                        end
                    end else if (bit_r == eeprom_slave_pkg::BIT_LAST) begin
                        // eight bits seen: decide on the ack
                        ack_phase_nxt = 1'b1;
                        bit_nxt = eeprom_slave_pkg::BIT_ACK;
                        sda_oe_nxt = 1'b0;
                        case (phase_r)
                            eeprom_slave_pkg::ST_SEL: begin
                                if (sel_match(shift_r, cs_s2_r)) begin
                                    sda_oe_nxt = 1'b1;
                                    if (shift_r[eeprom_slave_pkg::SEL_RW_BIT])
                                    begin
                                        phase_nxt = eeprom_slave_pkg::ST_RDATA;
                                        rd_nack_nxt = 1'b0;
                                    end else begin
                                        phase_nxt =
                                            eeprom_slave_pkg::ST_ADDR_HI;
                                    end
                                end else begin
                                    phase_nxt = eeprom_slave_pkg::ST_IGNORE;
                                    ack_phase_nxt = 1'b0;
                                end
                            end
                            eeprom_slave_pkg::ST_ADDR_HI: begin
                                sda_oe_nxt = 1'b1;
                                addr_nxt[15:8] = shift_r;
                                phase_nxt = eeprom_slave_pkg::ST_ADDR_LO;
                            end
                            eeprom_slave_pkg::ST_ADDR_LO: begin
                                sda_oe_nxt = 1'b1;
                                addr_nxt[7:0] = shift_r;
                                phase_nxt = eeprom_slave_pkg::ST_WDATA;
                            end
                            eeprom_slave_pkg::ST_WDATA: begin
                                // protected: no ack, nothing stored
                                if (!wp_s2_r && !wr_pend_r) begin
                                    sda_oe_nxt = 1'b1;
                                    wr_pend_nxt = 1'b1;
                                    wbuf_nxt = shift_r;
                                    waddr_nxt = addr_r;
                                    addr_nxt = addr_r + 16'h0001;
                                end
                            end
                            default: begin
                                sda_oe_nxt = 1'b0;
                            end
                        endcase
                        if (phase_r == eeprom_slave_pkg::ST_RDATA) begin
                            sda_oe_nxt = 1'b0; // master acks here
                        end
                    end else begin
                        bit_nxt = bit_r + 4'h1;
                        if (phase_r == eeprom_slave_pkg::ST_RDATA) begin
                            sda_oe_nxt = !tx_r[3'(6 - bit_r)];
                        end else begin
                            sda_oe_nxt = 1'b0;
                        end
                    end
                end
            endcase
        end
        // busy flag follows the countdown, registered for the pin
        busy_nxt = (pcnt_nxt != '0);
    end

    // state registers
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_r <= eeprom_slave_pkg::ST_IDLE;
            bit_r <= '0;
            shift_r <= '0;
            addr_r <= '0;
            tx_r <= '0;
            sda_oe_r <= 1'b0;
            ack_phase_r <= 1'b0;
            busy_r <= 1'b0;
            rd_nack_r <= 1'b0;
            wr_pend_r <= 1'b0;
            wbuf_r <= '0;
            waddr_r <= '0;
            pcnt_r <= '0;
        end else begin
            phase_r <= phase_nxt;
            bit_r <= bit_nxt;
            shift_r <= shift_nxt;
            addr_r <= addr_nxt;
            tx_r <= tx_nxt;
            sda_oe_r <= sda_oe_nxt;
            ack_phase_r <= ack_phase_nxt;
            busy_r <= busy_nxt;
            rd_nack_r <= rd_nack_nxt;
            wr_pend_r <= wr_pend_nxt;
            wbuf_r <= wbuf_nxt;
            waddr_r <= waddr_nxt;
            pcnt_r <= pcnt_nxt;
        end
    end

    // byte-wide array, written at end of programming
    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem_r[waddr_r[ADDR_W-1:0]] <= wbuf_r;
        end
    end

    // open-drain: only ever drives low
    assign sda_out = 1'b0;
    assign sda_oe = sda_oe_r;
    assign prog_busy = busy_r;
endmodule // serial_eeprom_bus_slave

// ==== inc/eeprom_slave_pkg.sv ====
package eeprom_slave_pkg;
    // array geometry
    localparam int ADDR_W_LARGE = 16;
    localparam int DATA_W = 8;
    // select byte layout
    localparam int SEL_TYPE_HI = 7;
    localparam int SEL_TYPE_LO = 4;
    localparam int SEL_CS_HI = 3;
    localparam int SEL_CS_LO = 1;
    localparam int SEL_RW_BIT = 0;
    // device type identifier: value is arbitrary
    localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
    // bit counter values
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;
    // self-timed programming time
    localparam int PROG_TIME_US = 5;
    localparam int CLK_MHZ = 100;
    localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SEL, ST_ADDR_HI, ST_ADDR_LO, ST_WDATA, ST_RDATA, ST_IGNORE
    } phase_e;

    // conditions seen on the two-wire link
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } link_ev_s;
endpackage

// ==== design/link_sampler.sv ====
// samples clock and data pins, finds edges and bus conditions
module link_sampler (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // pins
    input wire logic scl_in,
    input wire logic sda_in,
    // decoded events
    output eeprom_slave_pkg::link_ev_s ev
);
    logic [1:0] scl_sync_r, scl_sync_nxt;
    logic [1:0] sda_sync_r, sda_sync_nxt;
    logic scl_d_r, scl_d_nxt;
    logic sda_d_r, sda_d_nxt;
    eeprom_slave_pkg::link_ev_s ev_r, ev_nxt;

    // two-stage synchronisers, then one history stage
    always_comb begin
        scl_sync_nxt = {scl_sync_r[0], scl_in};
        sda_sync_nxt = {sda_sync_r[0], sda_in};
        scl_d_nxt = scl_sync_r[1];
        sda_d_nxt = sda_sync_r[1];
        ev_nxt.start = scl_sync_r[1] && scl_d_r && sda_d_r && !sda_sync_r[1];
        ev_nxt.stop = scl_sync_r[1] && scl_d_r && !sda_d_r && sda_sync_r[1];
        ev_nxt.scl_rise = scl_sync_r[1] && !scl_d_r;
        ev_nxt.scl_fall = !scl_sync_r[1] && scl_d_r;
        ev_nxt.sda = sda_sync_r[1];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            ev_r <= '0;
        end else begin
            scl_sync_r <= scl_sync_nxt;
            sda_sync_r <= sda_sync_nxt;
            scl_d_r <= scl_d_nxt;
            sda_d_r <= sda_d_nxt;
            ev_r <= ev_nxt;
        end
    end

    assign ev = ev_r;
endmodule // link_sampler

// ==== testbench/eeprom_slave_checker.sv ====
// watches link pins and status of the memory slave
module eeprom_slave_checker #(
    parameter logic [3:0] DEV_TYPE = eeprom_slave_pkg::DEV_TYPE_DEFAULT,
    parameter int PROG_CYCLES = eeprom_slave_pkg::PROG_CYCLES
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // link
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_oe,
    // straps and status
    input wire logic chip_select_pin_0,
    input wire logic chip_select_pin_1,
    input wire logic chip_select_pin_2,
    input wire logic write_protect_input,
    input wire logic prog_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q, sda_q, busy_st_r;
    logic [3:0] nb_r;
    logic [7:0] sel_r;
    int busy_cnt_r;
    wire sel_ok = sel_r[7:4] == DEV_TYPE && !busy_st_r && sel_r[3:1] ==
        {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
    // tracks the first byte after a start and the busy length
    always_ff @(posedge clk) begin
        scl_q <= scl_in;
        sda_q <= sda_in;
        busy_cnt_r <= prog_busy ? busy_cnt_r + 1 : 0;
        if (!reset_n) begin
            nb_r <= 4'h9;
            busy_st_r <= 1'b0;
        end else if (scl_q && scl_in && sda_q && !sda_in) begin
            nb_r <= 4'h0;
            busy_st_r <= prog_busy;
        end else if (scl_in && !scl_q && nb_r != 4'h9) begin
            nb_r <= nb_r + 4'h1;
            sel_r <= nb_r[3] ? sel_r : {sel_r[6:0], sda_in};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ninth rising clock edge after a start
    sequence ack_slot_s;
        scl_in && !scl_q && nb_r == 4'h8;
    endsequence
    sel_ack_a:
        assert property (ack_slot_s ##0 sel_ok |-> sda_oe)
        else $error("matching select not acknowledged");
    sel_skip_a:
        assert property (nb_r[3] && !sel_ok |-> !sda_oe)
        else $error("data line driven after foreign select");
    oe_scl_low_a:
        assert property ($changed(sda_oe) |-> !scl_in)
        else $error("data drive changed while clock high");
    busy_len_a:
        assert property ($fell(prog_busy) |-> busy_cnt_r == PROG_CYCLES)
        else $error("programming cycle length wrong");
    busy_at_stop_a:
        assert property ($rose(prog_busy) |-> scl_in && sda_in)
        else $error("programming started outside a stop");
    busy_wp_a:
        assert property ($rose(prog_busy) |-> !write_protect_input)
        else $error("programming while protected");
    busy_quiet_a:
        assert property (prog_busy |-> !sda_oe)
        else $error("data line driven while programming");
    reset_quiet_a:
        assert property (disable iff (1'b0)
            !reset_n |=> !sda_oe && !prog_busy)
        else $error("outputs active after reset");
endmodule // eeprom_slave_checker

bind serial_eeprom_bus_slave eeprom_slave_checker #(.DEV_TYPE(DEV_TYPE),
    .PROG_CYCLES(PROG_CYCLES)) chk (.clk(clk), .reset_n(reset_n),
    .scl_in(scl_in), .sda_in(sda_in), .sda_oe(sda_oe),
    .chip_select_pin_0(chip_select_pin_0),
    .chip_select_pin_1(chip_select_pin_1),
    .chip_select_pin_2(chip_select_pin_2),
    .write_protect_input(write_protect_input), .prog_busy(prog_busy));

// ==== testbench/bus_master_model.sv ====
// bus master: makes the clock, releases data to the pull-up
module bus_master_model (
    // clock
    input wire logic clk,
    // link
    input wire logic sda_line,
    output logic scl,
    output logic sda_hi
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock stands high between frames, data released
    initial begin
        scl = 1'b1;
        sda_hi = 1'b1;
    end
    task automatic q(input int n);
        repeat (n) @(negedge clk);
    endtask
    // start (st high) or stop: data moves while clock is high
    task automatic frame(input logic st);
        sda_hi = st;
        q(8);
        scl = 1'b1;
        q(4);
        sda_hi = ~st;
        q(4);
        scl = ~st;
        q(4);
    endtask
    // byte msb first, then ack bit; set while low, sampled mid high
    task automatic xfer(input logic [7:0] d, input logic ack_out,
        output logic [7:0] r, output logic ack);
        logic [8:0] w;
        w = {d, ~ack_out};
        for (int i = 8; i >= 0; i--) begin
            sda_hi = w[i];
            q(4);
            scl = 1'b1;
            q(4);
            w[i] = sda_line;
            q(4);
            scl = 1'b0;
            q(4);
        end
        r = w[8:1];
        ack = ~w[0];
    endtask
endmodule // bus_master_model

// ==== testbench/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [3:0] TID = 4'h9; // arbitrary type value
    localparam logic [2:0] CS = 3'h5;
    localparam int PROG = 400; // long enough to cover a whole refused byte
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp = 1'b0;
    logic [2:0] strap_cs = CS;
    logic scl, sda_hi, sda_out, sda_oe, prog_busy, k;
    logic [7:0] d0, d1, s;
    int bad_count = 0;
    int n_checks = 0;
    // open-drain data line with pull-up
    wire sda = sda_hi & ~(sda_oe & ~sda_out);
    // 100 MHz clock
    always #5 clk = ~clk;
    bus_master_model m (.clk(clk), .sda_line(sda), .scl(scl),
        .sda_hi(sda_hi));
    serial_eeprom_bus_slave #(.DEV_TYPE(TID), .PROG_CYCLES(PROG)) dut (
        .clk(clk), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe(sda_oe),
        .chip_select_pin_0(strap_cs[0]),
        .chip_select_pin_1(strap_cs[1]), .chip_select_pin_2(strap_cs[2]),
        .write_protect_input(wp), .prog_busy(prog_busy));
    task automatic check(input logic [7:0] v, input logic [7:0] e);
        n_checks++;
        if (v !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, v, e);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // send a byte and compare its acknowledge
    task automatic tx(input logic [7:0] b, input logic e);
        m.xfer(b, 1'b0, s, k);
        check(8'(k), 8'(e));
    endtask
    // select and address, then write a byte or read two back
    task automatic access(input logic [15:0] a, input logic [7:0] d,
        input logic rd, input logic dack);
        m.frame(1'b1);
        tx({TID, CS, 1'b0}, 1'b1);
        tx(a[15:8], 1'b1);
        tx(a[7:0], 1'b1);
        if (rd) begin
            m.frame(1'b1);
            tx({TID, CS, 1'b1}, 1'b1);
            m.xfer(8'hFF, 1'b1, d0, k);
            m.xfer(8'hFF, 1'b0, d1, k);
        end else begin
            tx(d, dack);
        end
        m.frame(1'b0);
    endtask
    // waits a bounded time for the programming flag to reach v
    task automatic busy_is(input logic v, input int lim);
        for (int n = 0; n < lim && prog_busy !== v; n++)
            @(negedge clk);
        check(8'(prog_busy), 8'(v));
    endtask
    // byte writes; a start while programming is ignored
    task automatic t_write();
        access(16'h0123, 8'h3C, 1'b0, 1'b1);
        busy_is(1'b1, 16);
        m.frame(1'b1);
        tx({TID, CS, 1'b0}, 1'b0);
        m.frame(1'b0);
        busy_is(1'b0, PROG + 40);
        access(16'h0124, 8'hA5, 1'b0, 1'b1);
        busy_is(1'b1, 16);
        busy_is(1'b0, PROG + 40);
    endtask
    // two bytes back: master ack, then noack and stop
    task automatic t_read();
        access(16'h0123, 8'h00, 1'b1, 1'b0);
        check(d0, 8'h3C);
        check(d1, 8'hA5);
    endtask
    // foreign type code, then each chip-select bit flipped
    task automatic t_skip();
        for (int i = 0; i < 4; i++) begin
            s = {TID, CS ^ 3'(1 << (i - 1)), 1'b0};
            m.frame(1'b1);
            tx(i == 0 ? {4'h6, CS, 1'b0} : s, 1'b0);
            tx(8'h01, 1'b0);
            m.frame(1'b0);
        end
    endtask
    // protected write: no data ack, no programming, byte kept
    task automatic t_protect();
        wp = 1'b1;
        access(16'h0123, 8'h77, 1'b0, 1'b0);
        repeat (16) @(negedge clk);
        check(8'(prog_busy), 8'h00);
        wp = 1'b0;
        access(16'h0123, 8'h00, 1'b1, 1'b0);
        check(d0, 8'h3C);
    endtask
    // other strap value; a second data byte of a write is refused
    task automatic t_straps();
        strap_cs = 3'h2;
        repeat (4) @(negedge clk);
        m.frame(1'b1);
        tx({TID, CS, 1'b0}, 1'b0);
        m.frame(1'b0);
        m.frame(1'b1);
        tx({TID, 3'h2, 1'b0}, 1'b1);
        tx(8'h01, 1'b1);
        tx(8'h24, 1'b1);
        tx(8'h5A, 1'b1);
        tx(8'hC3, 1'b0);
        m.frame(1'b0);
        busy_is(1'b1, 16);
        busy_is(1'b0, PROG + 40);
        strap_cs = CS;
        repeat (4) @(negedge clk);
        access(16'h0123, 8'h00, 1'b1, 1'b0);
        check(d0, 8'h3C);
        check(d1, 8'h5A);
    endtask
    // reset, then the scenarios in turn
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        repeat (4) @(negedge clk);
        t_write();
        t_read();
        t_skip();
        t_protect();
        t_straps();
        give_verdict();
    end
    // watchdog: the run needs about 8000 clocks
    initial begin
        #300000;
        bad_count++;
        give_verdict();
    end
endmodule // testbench
